// >>> logic/sbs_pkg.sv
package sbs_pkg;
	// Address and data geometry of the processor and main store.
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	// A sector is 1K bytes, which is 512 words of two bytes each.
	localparam int SECTOR_BYTES = 1024;
	localparam int WORD_BYTES = 2;
	localparam int SECT_WORDS = SECTOR_BYTES / WORD_BYTES;
	localparam int OFS_W = $clog2(SECT_WORDS);
	localparam int TAG_W = ADDR_W - OFS_W;
	// Buffer geometry: four sectors, each split into validity blocks of 8 words.
	localparam int NSECT = 4;
	localparam int SECT_W = $clog2(NSECT);
	localparam int BLK_WORDS = 8;
	localparam int BLK_W = $clog2(SECT_WORDS / BLK_WORDS);
	localparam int NBLK = SECT_WORDS / BLK_WORDS;
	localparam int BUF_AW = SECT_W + OFS_W;
	// Word-associative mode holds this many words, each with its full address.
	localparam int NWORD = 16;
	localparam int WIDX_W = $clog2(NWORD);
	// Activity counters are this wide; a hit on a counter at ACT_MAX halves them all.
	localparam int ACT_W = 4;
	localparam logic [ACT_W-1:0] ACT_MAX = 4'hF;
	// Word-mode usage bit reset value.
	localparam logic USED_RST = 1'b0;

	typedef enum logic [1:0]
	{
		SBS_IDLE = 2'b00,
		SBS_LOOK = 2'b01,
		SBS_MAIN = 2'b10,
		SBS_DONE = 2'b11
	} sbs_state_e;
endpackage

// >>> logic/sbs_ram.sv
`timescale 1ns/100ps
module sbs_ram #(
	parameter int AW = 8,
	parameter int DW = 16
) (
	// Clock.
	input wire logic clk_sys,
	// Write port.
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port with registered data.
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// No reset on storage; validity flags guard against stale contents except in unfetched words of a block whose flag is set.
	always_ff @(posedge clk_sys)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule

// >>> logic/sbs_top.sv
`timescale 1ns/100ps
// Contract
// (R01) Buffer and main store are cut into equal 1K-byte sectors and whole sectors map onto buffer sectors.
// (R02) Every access compares the requested sector address with all sector tags at once.
// (R03) A reference to an unassigned sector reassigns the least active buffer sector and retags it; the code does so on reads only.
// (R04) A reassigned sector is not filled at once; words are fetched only when requested.
// (R05) Each buffer sector has one validity flag per block, all cleared on reassignment.
// (R06) A block copied from main store sets only its own validity flag; the code fetches one word and sets its whole block's flag.
// (R07) Every write goes through to main store, so nothing is ever copied back.
// (R08) In word mode each buffered word keeps its full main address in a matching tag entry.
// (R09) In word mode the tags are searched first; a match returns the word, else main store is read.
// (R10) In word mode rarely used entries are flagged and one of them is evicted for a new word; the code evicts entry 0 when no entry is empty or flagged.
// (R11) In sector mode a read hits only with a tag match and a set block validity flag.
// (R12) The processor is stalled until any miss or write-through main transfer completes.
module sbs_top (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Mode select: low for sector-associative, high for word-associative.
	input wire logic word_mode,
	// Processor request port.
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [sbs_pkg::ADDR_W-1:0] cpu_addr,
	input wire logic [sbs_pkg::DATA_W-1:0] cpu_wdata,
	output logic cpu_ready,
	output logic cpu_valid,
	output logic [sbs_pkg::DATA_W-1:0] cpu_rdata,
	output logic cpu_hit,
	// Main store port.
	output logic mem_req,
	output logic mem_we,
	output logic [sbs_pkg::ADDR_W-1:0] mem_addr,
	output logic [sbs_pkg::DATA_W-1:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [sbs_pkg::DATA_W-1:0] mem_rdata
);
	localparam int NS = sbs_pkg::NSECT;
	localparam int NW = sbs_pkg::NWORD;

	sbs_pkg::sbs_state_e state_q;
	logic we_q;
	logic [sbs_pkg::ADDR_W-1:0] addr_q;
	logic [sbs_pkg::DATA_W-1:0] wdata_q;
	logic [sbs_pkg::TAG_W-1:0] stag_q [NS];
	logic [NS-1:0] sused_q;
	logic [sbs_pkg::NBLK-1:0] valid_q [NS];
	logic [sbs_pkg::ACT_W-1:0] act_q [NS];
	logic [sbs_pkg::ADDR_W-1:0] wtag_q [NW];
	logic [NW-1:0] wused_q;
	logic [NW-1:0] wref_q;
	logic [sbs_pkg::DATA_W-1:0] wdat_q [NW];
	logic [sbs_pkg::DATA_W-1:0] rdata_q;
	logic hit_q;
	logic valid_out_q;
	logic mreq_q;

	// Address fields of the latched request.
	wire [sbs_pkg::TAG_W-1:0] req_tag = addr_q[sbs_pkg::ADDR_W-1:sbs_pkg::OFS_W]; // R01
	wire [sbs_pkg::OFS_W-1:0] req_ofs = addr_q[sbs_pkg::OFS_W-1:0];
	wire [sbs_pkg::BLK_W-1:0] req_blk = req_ofs[sbs_pkg::OFS_W-1:sbs_pkg::OFS_W-sbs_pkg::BLK_W];

	// Parallel compare of all sector tags.
	logic [NS-1:0] s_match;
	logic [sbs_pkg::SECT_W-1:0] s_hit_idx;
	logic [sbs_pkg::SECT_W-1:0] s_victim;
	logic [NW-1:0] w_match;
	logic [sbs_pkg::WIDX_W-1:0] w_hit_idx;
	logic [sbs_pkg::WIDX_W-1:0] w_victim;

	always_comb
	begin
		s_hit_idx = '0;
		s_victim = '0;
		for (int i = 0; i < NS; i++)
		begin
			s_match[i] = sused_q[i] && (stag_q[i] == req_tag); // R02
			if (s_match[i])
				s_hit_idx = i[sbs_pkg::SECT_W-1:0];
		end
		// Unused sectors are taken first, then the one with the lowest activity.
		for (int i = NS - 1; i >= 0; i--)
		begin
			if (!sused_q[i])
				s_victim = i[sbs_pkg::SECT_W-1:0];
		end
		if (&sused_q)
		begin
			for (int i = NS - 1; i >= 0; i--)
			begin
				if (act_q[i] <= act_q[s_victim])
					s_victim = i[sbs_pkg::SECT_W-1:0]; // R03
			end
		end
	end

	always_comb
	begin
		w_hit_idx = '0;
		w_victim = '0;
		for (int i = 0; i < NW; i++)
		begin
			w_match[i] = wused_q[i] && (wtag_q[i] == addr_q); // R09
			if (w_match[i])
				w_hit_idx = i[sbs_pkg::WIDX_W-1:0];
		end
		// Prefer an empty slot, then one flagged as not referenced lately.
		for (int i = NW - 1; i >= 0; i--)
		begin
			if (!wref_q[i])
				w_victim = i[sbs_pkg::WIDX_W-1:0]; // R10
		end
		for (int i = NW - 1; i >= 0; i--)
		begin
			if (!wused_q[i])
				w_victim = i[sbs_pkg::WIDX_W-1:0];
		end
	end

	wire s_any = |s_match;
	wire [sbs_pkg::SECT_W-1:0] s_slot = s_any ? s_hit_idx : s_victim;
	wire s_hit = s_any && valid_q[s_hit_idx][req_blk]; // R11
	wire w_any = |w_match;
	wire look_hit = word_mode ? w_any : s_hit;
	wire fill = (state_q == sbs_pkg::SBS_MAIN) && mem_ack && !we_q;
	wire all_ref = &(wref_q | ~wused_q | w_match);

	// Sector-mode data buffer with registered read.
	logic [sbs_pkg::DATA_W-1:0] buf_rdata;
	wire buf_we = (state_q == sbs_pkg::SBS_MAIN) && mem_ack && !word_mode
		&& (!we_q || s_any);
	wire [sbs_pkg::DATA_W-1:0] buf_wdata = we_q ? wdata_q : mem_rdata;

	sbs_ram #(
		.AW(sbs_pkg::BUF_AW),
		.DW(sbs_pkg::DATA_W)
	) u_buf (
		.clk_sys(clk_sys),
		.we(buf_we),
		.waddr({s_slot, req_ofs}),
		.wdata(buf_wdata),
		.raddr({s_hit_idx, req_ofs}),
		.rdata(buf_rdata)
	);

	assign cpu_ready = (state_q == sbs_pkg::SBS_IDLE); // R12
	assign cpu_valid = valid_out_q;
	assign cpu_rdata = rdata_q;
	assign cpu_hit = hit_q;
	assign mem_req = mreq_q;
	assign mem_we = we_q;
	assign mem_addr = addr_q;
	assign mem_wdata = wdata_q;

	// Request sequencing.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			state_q <= sbs_pkg::SBS_IDLE;
			we_q <= 1'b0;
			addr_q <= '0;
			wdata_q <= '0;
			mreq_q <= 1'b0;
			valid_out_q <= 1'b0;
			hit_q <= 1'b0;
		end
		else
		begin
			valid_out_q <= 1'b0;
			unique case (state_q)
				sbs_pkg::SBS_IDLE:
					if (cpu_req)
					begin
						we_q <= cpu_we;
						addr_q <= cpu_addr;
						wdata_q <= cpu_wdata;
						state_q <= sbs_pkg::SBS_LOOK;
					end
				sbs_pkg::SBS_LOOK:
					if (look_hit && !we_q)
					begin
						hit_q <= 1'b1;
						state_q <= sbs_pkg::SBS_DONE;
					end
					else
					begin
						// Writes always reach main store.
						hit_q <= look_hit;
						mreq_q <= 1'b1; // R07 R12
						state_q <= sbs_pkg::SBS_MAIN;
					end
				sbs_pkg::SBS_MAIN:
					if (mem_ack)
					begin
						mreq_q <= 1'b0;
						valid_out_q <= !we_q;
						state_q <= sbs_pkg::SBS_IDLE; // R12
					end
				sbs_pkg::SBS_DONE:
				begin
					valid_out_q <= 1'b1;
					state_q <= sbs_pkg::SBS_IDLE;
				end
			endcase
		end
	end

	// Returned data: buffer word on a hit, main store word on a fill.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rdata_q <= '0;
		else if (fill)
			rdata_q <= mem_rdata; // R09 R11
		else if (state_q == sbs_pkg::SBS_DONE)
			rdata_q <= word_mode ? wdat_q[w_hit_idx] : buf_rdata;
	end

	// Sector tags, validity flags and activity counters.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sused_q <= '0;
			for (int i = 0; i < NS; i++)
			begin
				stag_q[i] <= '0;
				valid_q[i] <= '0;
				act_q[i] <= '0;
			end
		end
		else if (!word_mode)
		begin
			if (state_q == sbs_pkg::SBS_LOOK && !s_any && !we_q)
			begin
				// Claim the sector only; its data arrives word by word on demand.
				sused_q[s_victim] <= 1'b1;
				stag_q[s_victim] <= req_tag; // R03 R04
				valid_q[s_victim] <= '0; // R05
			end
			if (fill)
				valid_q[s_slot][req_blk] <= 1'b1; // R06
			if (state_q == sbs_pkg::SBS_LOOK && s_any)
			begin
				// Aging halves every counter when a hit finds its own sector's counter saturated, keeping relative order.
				for (int i = 0; i < NS; i++)
				begin
					if (act_q[s_hit_idx] == sbs_pkg::ACT_MAX)
						act_q[i] <= act_q[i] >> 1;
				end
				if (act_q[s_hit_idx] != sbs_pkg::ACT_MAX)
					act_q[s_hit_idx] <= act_q[s_hit_idx] + {{(sbs_pkg::ACT_W-1){1'b0}}, 1'b1};
			end
			if (state_q == sbs_pkg::SBS_LOOK && !s_any && !we_q)
				act_q[s_victim] <= '0;
		end
	end

	// Word-associative tag array with data and reference flags.
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			wused_q <= '0;
			wref_q <= {NW{sbs_pkg::USED_RST}};
			for (int i = 0; i < NW; i++)
			begin
				wtag_q[i] <= '0;
				wdat_q[i] <= '0;
			end
		end
		else if (word_mode && state_q == sbs_pkg::SBS_MAIN && mem_ack)
		begin
			if (we_q && w_any)
				wdat_q[w_hit_idx] <= wdata_q;
			else if (!we_q)
			begin
				wused_q[w_victim] <= 1'b1;
				wtag_q[w_victim] <= addr_q; // R08
				wdat_q[w_victim] <= mem_rdata;
				wref_q[w_victim] <= 1'b1;
			end
		end
		else if (word_mode && state_q == sbs_pkg::SBS_LOOK && w_any)
		begin
			// Once all are referenced, clear the others so the rarely used ones stand out.
			if (all_ref)
				wref_q <= w_match; // R10
			else
				wref_q[w_hit_idx] <= 1'b1;
		end
	end
endmodule

// >>> bench/sbs_mem_model.sv
`timescale 1ns/100ps
module sbs_mem_model (
	// Clock, pacing and main store port.
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	output logic mem_ack,
	output logic [15:0] mem_rdata
);
	logic [15:0] m [logic [15:0]];
	int w = 0;
	int n_wr = 0;
	initial mem_ack = 1'b0;
	initial mem_rdata = 16'h0;
	// Idle read data inverts every cycle, so a stale sample never matches.
	always @(posedge clk_sys)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (mem_req && !mem_ack)
			w++;
		if (mem_req && !mem_ack && w > (slow ? 3 : 0))
		begin
			w = 0;
			mem_ack <= 1'b1;
			n_wr += mem_we;
			if (mem_we)
				m[mem_addr] = mem_wdata;
			else
				mem_rdata <= m.exists(mem_addr) ? m[mem_addr] : mem_addr ^ 16'h5A5A;
		end
	end
endmodule

// >>> bench/sbs_top_properties.sv
`timescale 1ns/100ps
module sbs_top_properties (
	// Clock, reset, processor.
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cpu_req,
	input wire logic cpu_we,
	input wire logic [15:0] cpu_addr,
	input wire logic [15:0] cpu_wdata,
	input wire logic cpu_ready,
	input wire logic cpu_valid,
	input wire logic [15:0] cpu_rdata,
	input wire logic cpu_hit,
	// Main store.
	input wire logic mem_req,
	input wire logic mem_we,
	input wire logic [15:0] mem_addr,
	input wire logic [15:0] mem_wdata,
	input wire logic mem_ack,
	input wire logic [15:0] mem_rdata
);
	logic tk;
	logic lw_q;
	logic [15:0] la_q, ld_q;
	assign tk = cpu_req && cpu_ready;
	// No reset: only compared during a transfer, which always follows a take.
	always_ff @(posedge clk_sys)
		if (tk)
			{la_q, ld_q, lw_q} <= {cpu_addr, cpu_wdata, cpu_we};
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_ack;
		mem_req && mem_ack;
	endsequence
	a_take_stalls: assert property (tk |=> !cpu_ready)
		else $error("ready not dropped");
	a_mem_holds: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
		else $error("request not held");
	a_ack_ends: assert property (s_ack |=> !mem_req && cpu_ready)
		else $error("transfer not ended");
	a_miss_data: assert property (s_ack ##0 !mem_we |=>
		cpu_valid && cpu_rdata == $past(mem_rdata)) else $error("fetched word lost");
	a_write_thru: assert property (tk && cpu_we |-> ##[1:4] (mem_req && mem_we))
		else $error("write not forwarded");
	a_mem_addr: assert property (mem_req |-> mem_addr == la_q && mem_we == lw_q)
		else $error("wrong main address");
	a_mem_wdata: assert property (mem_req && mem_we |-> mem_wdata == ld_q)
		else $error("wrong write data");
	a_hit_source: assert property (cpu_valid |-> cpu_hit != $past(mem_ack))
		else $error("hit flag wrong");
	a_read_answer: assert property (tk && !cpu_we |-> ##[2:4] (mem_req || cpu_valid))
		else $error("read not answered");
endmodule
bind sbs_top sbs_top_properties u_sbs_top_properties (.clk_sys, .rst, .cpu_req, .cpu_we,
	.cpu_addr, .cpu_wdata, .cpu_ready, .cpu_valid, .cpu_rdata, .cpu_hit, .mem_req, .mem_we,
	.mem_addr, .mem_wdata, .mem_ack, .mem_rdata);

// >>> bench/tb.sv
`timescale 1ns/100ps
module tb;
	logic clk_sys = 1'b0, rst = 1'b1, word_mode = 1'b0, slow = 1'b0;
	logic cpu_req = 1'b0, cpu_we = 1'b0;
	logic [15:0] cpu_addr = 16'h0, cpu_wdata = 16'h0;
	logic cpu_ready, cpu_valid, cpu_hit, mem_req, mem_we, mem_ack;
	logic [15:0] cpu_rdata, mem_addr, mem_wdata, mem_rdata;
	logic [15:0] shadow [logic [15:0]];
	int n_fail = 0, n_compared = 0;
	always #25 clk_sys = ~clk_sys;
	sbs_top u_sbs_top (.clk_sys, .rst, .word_mode, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
		.cpu_ready, .cpu_valid, .cpu_rdata, .cpu_hit, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata);
	sbs_mem_model u_sbs_mem_model (.clk_sys, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
		.mem_ack, .mem_rdata);
	task complete_run;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic eh);
		int i;
		@(negedge clk_sys);
		cpu_req = 1'b1;
		cpu_we = w;
		cpu_addr = a;
		cpu_wdata = d;
		@(negedge clk_sys);
		cpu_req = 1'b0;
		for (i = 0; i < 60 && (w ? cpu_ready : cpu_valid) !== 1'b1; i++)
			@(negedge clk_sys);
		chk("done", 16'h1, 16'(i < 60));
		if (i == 60)
			complete_run;
		else if (w)
			shadow[a] = d;
		else
		begin
			chk("rdata", shadow.exists(a) ? shadow[a] : a ^ 16'h5A5A, cpu_rdata);
			chk("hit", 16'(eh), 16'(cpu_hit));
		end
	endtask
	task rd(input logic [15:0] a, input logic eh);
		acc(1'b0, a, 16'h0, eh);
	endtask
	task t_sector;
		rd(16'h0010, 1'b0);
		rd(16'h0010, 1'b1);
		rd(16'h0018, 1'b0);
		rd(16'h0010, 1'b1);
	endtask
	task t_write;
		int n;
		n = u_sbs_mem_model.n_wr;
		acc(1'b1, 16'h0010, 16'h1234, 1'b0);
		acc(1'b1, 16'h0400, 16'hBEEF, 1'b0);
		chk("writes", 16'(n + 2), 16'(u_sbs_mem_model.n_wr));
		rd(16'h0010, 1'b1);
		rd(16'h0400, 1'b0);
	endtask
	task t_reassign;
		slow = 1'b1;
		rd(16'h0200, 1'b0);
		rd(16'h0600, 1'b0);
		rd(16'h0400, 1'b1);
		rd(16'h0200, 1'b1);
		rd(16'h0800, 1'b0);
		rd(16'h0010, 1'b1);
		rd(16'h0600, 1'b0);
	endtask
	task t_word;
		int k;
		word_mode = 1'b1;
		for (k = 0; k < 17; k++)
			rd(16'h2000 + 16'(k), 1'b0);
		rd(16'h2010, 1'b1);
		// A write that hits in word mode must refresh the buffered copy as well.
		acc(1'b1, 16'h2010, 16'hA5C3, 1'b0);
		rd(16'h2010, 1'b1);
		rd(16'h200F, 1'b1);
		rd(16'h2000, 1'b0);
	endtask
	task t_reset;
		@(negedge clk_sys);
		rst = 1'b1;
		word_mode = 1'b0;
		@(negedge clk_sys);
		chk("rst_ready", 16'h1, 16'(cpu_ready));
		chk("rst_mem_req", 16'h0, 16'(mem_req));
		chk("rst_rdata", 16'h0, cpu_rdata);
		chk("rst_flags", 16'h0, {14'h0, cpu_valid, cpu_hit});
		@(negedge clk_sys);
		rst = 1'b0;
		// Tags were cleared, so a word that hit before must now miss.
		rd(16'h0010, 1'b0);
		rd(16'h0010, 1'b1);
	endtask
	initial
	begin
		repeat (20) @(negedge clk_sys);
		rst = 1'b0;
		t_sector;
		t_write;
		t_reassign;
		t_word;
		t_reset;
		complete_run;
	end
endmodule
